// *** phd_pkg.sv ***
// Package for the privileged handler dispatch controller
package phd_pkg;

    // ------------------------------------------------------------
    // Address widths and entry layout
    // ------------------------------------------------------------
    localparam int PC_W       = 34;
    localparam int OFS_W      = 14;
    localparam int BASE_LO    = 14;
    localparam int BASE_W     = 20;
    localparam int FUNC_W     = 8;
    localparam int INSTR_STEP = 4;

    // Handler entry offsets
    localparam logic [13:0] OFS_RESET   = 14'h0000;
    localparam logic [13:0] OFS_MCHK    = 14'h0020;
    localparam logic [13:0] OFS_ARITH   = 14'h0060;
    localparam logic [13:0] OFS_INTR    = 14'h00e0;
    localparam logic [13:0] OFS_DFAULT  = 14'h01e0;
    localparam logic [13:0] OFS_ITBMISS = 14'h03e0;
    localparam logic [13:0] OFS_DTBNAT  = 14'h08e0;
    localparam logic [13:0] OFS_DTBPRV  = 14'h09e0;
    localparam logic [13:0] OFS_UNALIGN = 14'h11e0;
    localparam logic [13:0] OFS_ILLEGAL_OPCODE_TRAP  = 14'h13e0;
    localparam logic [13:0] OFS_CALLPRV = 14'h2000;
    localparam logic [13:0] OFS_CALLUSR = 14'h3000;
    localparam int          CALL_SHIFT  = 6;

    // ------------------------------------------------------------
    // Register map of the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_BASE   = 4'h0;
    localparam logic [3:0] REG_RETADR = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_IRQ_ST = 4'h3;
    localparam logic [3:0] REG_IRQ_EN = 4'h4;
    localparam logic [3:0] REG_IRQ_CL = 4'h5;
    localparam logic [PC_W-1:0] BASE_RST = 34'h0;
    localparam int IRQ_W = 3;
    localparam int IRQ_ENTRY = 0;
    localparam int IRQ_RET   = 1;
    localparam int IRQ_ILLEG = 2;

    // Event request bundle from pipeline and sources
    typedef struct packed {
        logic       mchk;
        logic       arith;
        logic       intr;
        logic       dfault;
        logic       unalign;
        logic       dtb_miss;
        logic       itb_miss;
        logic       rsvd_op;
        logic       call;
        logic [7:0] call_func;
        logic       kernel;
        logic       ipr_rd;
        logic       ipr_wr;
        logic       phys_ld;
        logic       phys_st;
        logic       ret;
    } phd_evt_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_DRAIN = 2'b01,
        ST_SAVE  = 2'b10
    } phd_state_t;
endpackage

// *** phd_dispatch.sv ***
// Privileged handler mode controller with entry dispatch and return
//
// Contract
// - Drain pipeline before dispatching any handler; the reset entry is fetched at boot with no drain
// - Hardware saves PC in return address
// - Entry is base plus fixed offset
// - Handler mode: no mapping, no interrupts
// - Privileged instructions outside mode raise trap
// - Return jumps to saved return address
// - Return bit0 clear resumes native mode
// - Reset enters mode until native return
// - Hardware errors dispatch to their handler
// - Interrupts dispatch to interrupt handler
// - TB misses dispatch to fill handler
// - Handler call saves PC plus four
// - Entry offset low, base high; base resets zero
// - Highest priority cause wins, reset first
`timescale 1ns/100ps
module phd_dispatch
    import phd_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            reset_n,
    input  wire phd_evt_t        evt,
    input  wire logic [PC_W-1:0] cur_pc,
    input  wire logic            pipe_empty,
    output logic                 drain_req_q,
    output logic                 fetch_load_q,
    output logic [PC_W-1:0]      fetch_pc_q,
    output logic                 handler_mode_q,
    output logic                 map_enable_q,
    output logic                 intr_enable_q,
    output logic                 illegal_opcode_trap_q,
    input  wire logic [3:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata_q,
    output logic                 irq_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    phd_state_t            state_q, state_d;
    logic [PC_W-1:0]       handler_base_address_q;
    logic [PC_W-1:0]       exception_return_address_q;
    logic [OFS_W-1:0]      ofs_q;
    logic                  call_q;
    logic                  boot_q;
    logic [IRQ_W-1:0]      irq_st_q;
    logic [IRQ_W-1:0]      irq_en_q;

    // Entry address builder
    function automatic logic [PC_W-1:0] entry_pc(
        input logic [PC_W-1:0]  base,
        input logic [OFS_W-1:0] ofs);
        entry_pc = {base[PC_W-1:BASE_LO], ofs};
    endfunction

    // ------------------------------------------------------------
    // Privilege check and cause selection
    // ------------------------------------------------------------
    wire priv_op   = evt.ipr_rd | evt.ipr_wr | evt.phys_ld
                   | evt.phys_st | evt.ret;
    wire illeg     = priv_op & ~handler_mode_q;
    wire call_prv  = evt.call_func[7:6] == 2'b00;
    wire call_usr  = evt.call_func[7:6] == 2'b10;
    wire call_ok   = (call_prv & evt.kernel) | call_usr;
    wire [OFS_W-1:0] call_ofs =
        (call_prv ? OFS_CALLPRV : OFS_CALLUSR)
        | (OFS_W'(evt.call_func[5:0]) << CALL_SHIFT);
    wire intr_take = evt.intr & ~handler_mode_q;
    wire do_ret    = evt.ret & handler_mode_q;

    // Fixed priority, highest first
    logic            cause_any;
    logic [OFS_W-1:0] cause_ofs;
    always_comb begin
        cause_any = 1'b1;
        cause_ofs = OFS_RESET;
        if (evt.mchk) begin
            cause_ofs = OFS_MCHK;
        end else if (evt.arith) begin
            cause_ofs = OFS_ARITH;
        end else if (intr_take) begin
            cause_ofs = OFS_INTR;
        end else if (evt.dfault) begin
            cause_ofs = evt.unalign ? OFS_UNALIGN : OFS_DFAULT;
        end else if (evt.dtb_miss) begin
            cause_ofs = handler_mode_q ? OFS_DTBPRV : OFS_DTBNAT;
        end else if (evt.unalign) begin
            cause_ofs = OFS_UNALIGN;
        end else if (evt.itb_miss) begin
            cause_ofs = OFS_ITBMISS;
        end else if (evt.call & call_ok) begin
            cause_ofs = call_ofs;
        end else if (evt.rsvd_op | illeg | evt.call) begin
            cause_ofs = OFS_ILLEGAL_OPCODE_TRAP;
        end else begin
            cause_any = 1'b0;
        end
    end

    wire is_call = evt.call & call_ok & ~(evt.mchk | evt.arith
                 | intr_take | evt.dfault | evt.dtb_miss
                 | evt.unalign | evt.itb_miss);

    // ------------------------------------------------------------
    // Sequencer: run, drain, then save and dispatch
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (cause_any) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (pipe_empty) begin
                    state_d = ST_SAVE;
                end
            end
            ST_SAVE: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    wire run_take  = state_q == ST_RUN && cause_any;
    wire run_ret   = state_q == ST_RUN && !cause_any && do_ret;
    wire save_now  = state_q == ST_SAVE;
    wire [PC_W-1:0] save_pc =
        call_q ? cur_pc + PC_W'(INSTR_STEP) : cur_pc;

    // State, cause latch and boot dispatch
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RUN;
            ofs_q   <= OFS_RESET;
            call_q  <= 1'b0;
            boot_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            boot_q  <= 1'b0;
            if (run_take) begin
                ofs_q  <= cause_ofs;
                call_q <= is_call;
            end
        end
    end

    // Fetch redirect and drain request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drain_req_q  <= 1'b0;
            fetch_load_q <= 1'b0;
            fetch_pc_q   <= '0;
        end else begin
            drain_req_q  <= state_d == ST_DRAIN;
            fetch_load_q <= save_now | run_ret | boot_q;
            if (boot_q) begin
                fetch_pc_q <= entry_pc(handler_base_address_q,
                                       OFS_RESET);
            end else if (save_now) begin
                fetch_pc_q <= entry_pc(handler_base_address_q, ofs_q);
            end else if (run_ret) begin
                fetch_pc_q <= exception_return_address_q;
            end
        end
    end

    // Mode flag and its derived enables
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            handler_mode_q <= 1'b1;
            map_enable_q   <= 1'b0;
            intr_enable_q  <= 1'b0;
        end else if (save_now) begin
            handler_mode_q <= 1'b1;
            map_enable_q   <= 1'b0;
            intr_enable_q  <= 1'b0;
        end else if (run_ret) begin
            // Bit 0 clear leaves the mode, set keeps it
            handler_mode_q <= exception_return_address_q[0];
            map_enable_q   <= ~exception_return_address_q[0];
            intr_enable_q  <= ~exception_return_address_q[0];
        end
    end

    // Illegal opcode pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            illegal_opcode_trap_q <= 1'b0;
        end else begin
            illegal_opcode_trap_q <= run_take & illeg;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    wire wr_base = reg_wr && reg_addr == REG_BASE && handler_mode_q;
    wire wr_ret  = reg_wr && reg_addr == REG_RETADR && handler_mode_q;
    wire wr_en   = reg_wr && reg_addr == REG_IRQ_EN;
    wire wr_clr  = reg_wr && reg_addr == REG_IRQ_CL;

    // Base and return address; hardware save beats software write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            handler_base_address_q     <= BASE_RST;
            exception_return_address_q <= '0;
        end else begin
            if (wr_base) begin
                handler_base_address_q <=
                    {reg_wdata[BASE_W-1:0], {BASE_LO{1'b0}}};
            end
            if (save_now) begin
                exception_return_address_q <= save_pc;
            end else if (wr_ret) begin
                exception_return_address_q <=
                    {2'b00, reg_wdata};
            end
        end
    end

    // Sticky status: set wins over clear
    wire [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_ENTRY] = save_now;
    assign irq_set[IRQ_RET]   = run_ret;
    assign irq_set[IRQ_ILLEG] = run_take & illeg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~(wr_clr ? reg_wdata[IRQ_W-1:0]
                                             : '0)) | irq_set;
            if (wr_en) begin
                irq_en_q <= reg_wdata[IRQ_W-1:0];
            end
            irq_q <= |((irq_st_q | irq_set) & irq_en_q);
        end
    end

    // Read data, one cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (reg_addr)
            REG_BASE:   rd_mux = {12'h000,
                                  handler_base_address_q[PC_W-1:BASE_LO]};
            REG_RETADR: rd_mux = exception_return_address_q[31:0];
            REG_STATUS: rd_mux = {28'h0, illegal_opcode_trap_q,
                                  intr_enable_q, map_enable_q,
                                  handler_mode_q};
            REG_IRQ_ST: rd_mux = {29'h0, irq_st_q};
            REG_IRQ_EN: rd_mux = {29'h0, irq_en_q};
            default:    rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 32'h0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_enter;
        state_q == ST_SAVE;
    endsequence

    property p_drain;
        @(posedge clk_sys) disable iff (!reset_n)
        state_q == ST_SAVE |-> $past(pipe_empty);
    endproperty
    a_drain: assert property (p_drain)
        else $error("dispatch without drained pipe");

    property p_save;
        @(posedge clk_sys) disable iff (!reset_n)
        s_enter |=> exception_return_address_q == $past(save_pc);
    endproperty
    a_save: assert property (p_save)
        else $error("return address not saved");

    property p_entry;
        @(posedge clk_sys) disable iff (!reset_n)
        s_enter |=> fetch_load_q && fetch_pc_q[OFS_W-1:0] == $past(ofs_q);
    endproperty
    a_entry: assert property (p_entry)
        else $error("wrong entry offset");

    property p_mode;
        @(posedge clk_sys) disable iff (!reset_n)
        handler_mode_q |-> !map_enable_q && !intr_enable_q;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mapping or interrupts on in handler mode");

    property p_illeg;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_RUN && evt.ipr_rd && !handler_mode_q)
            |=> illegal_opcode_trap_q;
    endproperty
    a_illeg: assert property (p_illeg)
        else $error("no trap for privileged op");

    property p_ret;
        @(posedge clk_sys) disable iff (!reset_n)
        run_ret |=> fetch_pc_q == $past(exception_return_address_q)
                    && handler_mode_q == $past(exception_return_address_q[0]);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return target or mode wrong");

    property p_call;
        @(posedge clk_sys) disable iff (!reset_n)
        (s_enter and call_q) |=> exception_return_address_q
                                 == $past(cur_pc) + PC_W'(INSTR_STEP);
    endproperty
    a_call: assert property (p_call)
        else $error("call did not save next pc");

    property p_prio;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_RUN && evt.mchk) |=> ofs_q == OFS_MCHK;
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority not honoured");

endmodule

// *** phd_pipe_model.sv ***
// Pipeline stand-in that empties a set number of cycles into a drain
`timescale 1ns/100ps
module phd_pipe_model (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       drain_req_q,
    input  wire logic [3:0] drain_delay,
    output logic            pipe_empty
);
    // ------------------------------------------------------------
    // Drain progress
    // ------------------------------------------------------------
    logic [3:0] cnt_q;

    // Counts cycles spent draining, saturating
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
        end else if (!drain_req_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Busy unless a drain has run long enough
    assign pipe_empty = drain_req_q && (cnt_q >= drain_delay);
endmodule

// *** test_privileged_handler_dispatch.sv ***
// Self-checking bench for the handler dispatch controller
`timescale 1ns/100ps
module test_privileged_handler_dispatch;
    import phd_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_A    = 34'h2_8765_4320;
    localparam logic [19:0]     BASE_HI = 20'habcde;
    logic            clk_sys = 1'b0;
    logic            reset_n = 1'b0;
    phd_evt_t        evt = '0;
    logic [PC_W-1:0] cur_pc = PC_A;
    logic            pipe_empty;
    logic            drain_req_q, fetch_load_q, handler_mode_q;
    logic [PC_W-1:0] fetch_pc_q;
    logic            map_enable_q, intr_enable_q, illegal_opcode_trap_q;
    logic [3:0]      reg_addr = 4'h0;
    logic [31:0]     reg_wdata = 32'h0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata_q, rd;
    logic            irq_q, got, saw_trap;
    logic [3:0]      drain_delay = 4'h0;
    int              failures = 0;
    int              tests_run = 0;
    int              n_drain;

    always #4 clk_sys = ~clk_sys;

    phd_dispatch u_phd_dispatch (.clk_sys(clk_sys), .reset_n(reset_n),
        .evt(evt), .cur_pc(cur_pc), .pipe_empty(pipe_empty),
        .drain_req_q(drain_req_q), .fetch_load_q(fetch_load_q),
        .fetch_pc_q(fetch_pc_q), .handler_mode_q(handler_mode_q),
        .map_enable_q(map_enable_q), .intr_enable_q(intr_enable_q),
        .illegal_opcode_trap_q(illegal_opcode_trap_q),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));

    phd_pipe_model u_phd_pipe_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .drain_req_q(drain_req_q), .drain_delay(drain_delay),
        .pipe_empty(pipe_empty));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata_q;
    endtask

    // One-hot cause by index, with call function and kernel flag
    function automatic phd_evt_t ev(input int n, input logic [7:0] f,
                                    input logic k);
        logic [$bits(phd_evt_t)-1:0] v;
        v = '0;
        v[(n < 9) ? 22 - n : 14 - n] = 1'b1;
        ev = phd_evt_t'(v);
        ev.call_func = f;
        ev.kernel = ev.kernel | k;
    endfunction

    // One-cycle request, then watch for a redirect
    task automatic pulse_wait(input phd_evt_t e, input int n);
        got = 1'b0;
        saw_trap = 1'b0;
        n_drain = 0;
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= '0;
        for (int i = 0; i < n && !got; i++) begin
            @(negedge clk_sys);
            if (drain_req_q === 1'b1) n_drain++;
            if (illegal_opcode_trap_q === 1'b1) saw_trap = 1'b1;
            if (fetch_load_q === 1'b1) got = 1'b1;
        end
    endtask

    task automatic do_evt(input phd_evt_t e, input logic [PC_W-1:0] pc,
                          input logic mode);
        pulse_wait(e, 40);
        check(got, 1'b1);
        check(fetch_pc_q, pc);
        check(handler_mode_q, mode);
        check(map_enable_q, !mode);
        check(intr_enable_q, !mode);
    endtask

    task automatic go_native();
        reg_write(REG_RETADR, 32'h0000_4000);
        do_evt(ev(14, 8'h00, 1'b0), 34'h4000, 1'b0);
    endtask

    // rsel: 0 saved pc, 1 saved pc plus four, 2 not checked
    task automatic run_case(input phd_evt_t e, input logic [13:0] ofs,
                            input int rsel, input logic trap);
        // Leave handler mode first; a return in native mode would trap
        if (handler_mode_q === 1'b1) begin
            go_native();
        end
        do_evt(e, {BASE_HI, ofs}, 1'b1);
        check(n_drain != 0, 1'b1);
        check(saw_trap, trap);
        if (rsel != 2) begin
            reg_read(REG_RETADR, rd);
            check(rd, PC_A[31:0] + ((rsel == 1) ? 32'h4 : 32'h0));
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (12) @(posedge clk_sys);
        check(handler_mode_q, 1'b1);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check(fetch_load_q, 1'b1);
        check(fetch_pc_q, 34'h0);
        check({map_enable_q, intr_enable_q}, 2'b00);
        reg_read(REG_BASE, rd);
        check(rd, 32'h0);
        reg_write(REG_BASE, {12'h000, BASE_HI});
        reg_read(REG_BASE, rd);
        check(rd, {12'h000, BASE_HI});
    endtask

    task automatic t_returns();
        reg_write(REG_RETADR, 32'h0000_1001);
        do_evt(ev(14, 8'h00, 1'b0), 34'h1001, 1'b1);
        go_native();
        reg_read(REG_STATUS, rd);
        check(rd, 32'h6);
        reg_write(REG_BASE, 32'h1);
        reg_read(REG_BASE, rd);
        check(rd, {12'h000, BASE_HI});
        reg_read(4'hf, rd);
        check(rd, 32'h0);
    endtask

    task automatic t_causes();
        run_case(ev(0, 8'h00, 0), OFS_MCHK, 0, 0);
        pulse_wait(ev(2, 8'h00, 0), 8);
        check(got, 1'b0);
        run_case(ev(1, 8'h00, 0), OFS_ARITH, 0, 0);
        run_case(ev(2, 8'h00, 0), OFS_INTR, 0, 0);
        run_case(ev(3, 8'h00, 0), OFS_DFAULT, 0, 0);
        run_case(ev(3, 8'h00, 0) | ev(4, 8'h00, 0), OFS_UNALIGN, 0, 0);
        run_case(ev(5, 8'h00, 0), OFS_DTBNAT, 0, 0);
        do_evt(ev(5, 8'h00, 0), {BASE_HI, OFS_DTBPRV}, 1'b1);
        run_case(ev(4, 8'h00, 0), OFS_UNALIGN, 0, 0);
        run_case(ev(6, 8'h00, 0), OFS_ITBMISS, 0, 0);
        run_case(ev(7, 8'h00, 0), OFS_ILLEGAL_OPCODE_TRAP, 0, 0);
        run_case(ev(8, 8'h05, 1), 14'h2140, 1, 0);
        run_case(ev(8, 8'h85, 0), 14'h3140, 1, 0);
        run_case(ev(8, 8'h05, 0), OFS_ILLEGAL_OPCODE_TRAP, 2, 0);
        run_case(ev(8, 8'h45, 1), OFS_ILLEGAL_OPCODE_TRAP, 2, 0);
        for (int n = 10; n < 15; n++) begin
            run_case(ev(n, 8'h00, 0), OFS_ILLEGAL_OPCODE_TRAP, 2, 1);
        end
        run_case(ev(0, 8'h00, 0) | ev(2, 8'h00, 0) | ev(6, 8'h00, 0),
                 OFS_MCHK, 0, 0);
        drain_delay <= 4'h5;
        run_case(ev(6, 8'h00, 0), OFS_ITBMISS, 0, 0);
        check(n_drain, 6);
        drain_delay <= 4'h0;
    endtask

    task automatic t_irq();
        go_native();
        reg_write(REG_IRQ_CL, 32'h7);
        reg_write(REG_IRQ_EN, 32'h1);
        reg_read(REG_IRQ_ST, rd);
        check({rd, irq_q}, {32'h0, 1'b0});
        run_case(ev(0, 8'h00, 0), OFS_MCHK, 0, 0);
        reg_read(REG_IRQ_ST, rd);
        check({rd, irq_q}, {32'h1, 1'b1});
        reg_write(REG_IRQ_EN, 32'h0);
        reg_read(REG_IRQ_ST, rd);
        check({rd, irq_q}, {32'h1, 1'b0});
        reg_write(REG_IRQ_EN, 32'h1);
        reg_write(REG_IRQ_CL, 32'h1);
        reg_read(REG_IRQ_ST, rd);
        check({rd, irq_q}, {32'h0, 1'b0});
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        t_reset();
        t_returns();
        t_causes();
        t_irq();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        summarize();
    end
endmodule
